// ### dv/lin_control_status_regs_test.sv
// self-checking bench of the lin control and status registers
`timescale 1ns/10ps
`include "lin_regs_cfg.svh"
module lin_control_status_regs_test
  import lin_regs_pkg::*;
;
  localparam logic [9:0] EV_BRK = 10'h100;
  localparam logic [9:0] EV_DONE = 10'h040;
  localparam logic [9:0] EV_ERR = 10'h020;
  localparam logic [9:0] EV_SLP = 10'h010;
  localparam logic [9:0] EV_WRX = 10'h008;
  localparam logic [9:0] EV_DREQ = 10'h002;
  localparam logic [9:0] EV_IRQ = 10'h001;

  logic        clk;
  logic        resetn;
  logic        addr_wr;
  logic        data_wr;
  logic [7:0]  wdata;
  logic        master_mode;
  lin_events_t inj;
  lin_events_t events;
  logic [7:0]  addr_q;
  logic [7:0]  rdata_q;
  lin_cmds_t   cmds;
  int          mismatches;
  int          num_checks;
  int          cycles;

  lin_control_status_regs #(.IDLE_CYCLES(20)) i_dut (
    .clk(clk), .resetn(resetn), .addr_wr(addr_wr), .data_wr(data_wr), .wdata(wdata),
    .master_mode(master_mode), .events(events), .addr_q(addr_q), .rdata_q(rdata_q),
    .cmds_q(cmds));
  lin_engine_model i_engine (
    .clk(clk), .resetn(resetn), .cmds(cmds), .inject(inj), .events(events));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) addr_wr = 1'b1;
    wdata = a;
    @(negedge clk) addr_wr = 1'b0;
    data_wr = 1'b1;
    wdata = d;
    @(negedge clk) data_wr = 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk) addr_wr = 1'b1;
    wdata = a;
    @(negedge clk) addr_wr = 1'b0;
    @(negedge clk);
    check("addr", addr_q, a);
    check($sformatf("reg %h", a), rdata_q, exp);
  endtask

  task automatic pulse(input logic [9:0] m);
    @(negedge clk) inj = lin_events_t'(inj | m);
    @(negedge clk) inj = lin_events_t'(inj & ~m);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    resetn = 1'b0;
    addr_wr = 1'b0;
    data_wr = 1'b0;
    wdata = 8'h00;
    master_mode = 1'b0;
    inj = lin_events_t'(10'h200);
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    check("cmds", 8'(cmds), 8'h00);
    check("rdata", rdata_q, 8'h00);
    rreg(8'h08, 8'h00);
    rreg(8'h09, 8'h80);
    rreg(8'h0A, 8'h00);
    wreg(8'h09, 8'hFF);
    rreg(8'h09, 8'h80);
    $display("test reset done");
    wreg(8'h08, 8'h0C);
    rreg(8'h08, 8'h00);
    wreg(8'h08, 8'h80);
    check("halt", 8'(cmds.halt), 8'h01);
    rreg(8'h08, 8'h00);
    rreg(8'h09, 8'hA0);
    pulse(EV_BRK);
    // halt command drops one edge after the break clears the stored halt
    @(negedge clk);
    check("halt", 8'(cmds.halt), 8'h00);
    rreg(8'h09, 8'h80);
    inj.frame_busy = 1'b1;
    pulse(EV_BRK);
    rreg(8'h09, 8'hA0);
    inj.frame_busy = 1'b0;
    pulse(EV_BRK);
    rreg(8'h09, 8'h80);
    $display("test halt done");
    wreg(8'h08, 8'h20);
    rreg(8'h08, 8'h20);
    check("dir", 8'(cmds.direction), 8'h01);
    wreg(8'h08, 8'h00);
    // direction reaches the engine two edges after the write
    @(negedge clk);
    check("dir", 8'(cmds.direction), 8'h00);
    pulse(EV_DREQ);
    rreg(8'h09, 8'h90);
    wreg(8'h08, 8'h10);
    check("ack", 8'(cmds.data_ack), 8'h01);
    rreg(8'h08, 8'h00);
    rreg(8'h09, 8'h80);
    pulse(EV_IRQ);
    rreg(8'h09, 8'h88);
    wreg(8'h08, 8'h08);
    rreg(8'h09, 8'h80);
    pulse(EV_ERR);
    repeat (5) @(negedge clk);
    rreg(8'h09, 8'h84);
    wreg(8'h08, 8'h04);
    check("eclr", 8'(cmds.error_clear), 8'h01);
    rreg(8'h09, 8'h80);
    $display("test strobes done");
    master_mode = 1'b1;
    wreg(8'h08, 8'h01);
    check("start", 8'(cmds.frame_start), 8'h01);
    rreg(8'h08, 8'h01);
    pulse(EV_DONE);
    rreg(8'h08, 8'h00);
    rreg(8'h09, 8'h81);
    wreg(8'h08, 8'h01);
    rreg(8'h09, 8'h80);
    pulse(EV_ERR);
    rreg(8'h08, 8'h00);
    rreg(8'h09, 8'h84);
    wreg(8'h08, 8'h04);
    wreg(8'h08, 8'hD0);
    check("halt", 8'(cmds.halt), 8'h00);
    rreg(8'h08, 8'h00);
    master_mode = 1'b0;
    wreg(8'h08, 8'h01);
    check("start", 8'(cmds.frame_start), 8'h00);
    rreg(8'h08, 8'h00);
    $display("test master done");
    wreg(8'h08, 8'h02);
    check("wake", 8'(cmds.wakeup_send), 8'h01);
    rreg(8'h08, 8'h02);
    repeat (12) @(negedge clk);
    rreg(8'h08, 8'h00);
    pulse(EV_BRK);
    inj.bus_active = 1'b0;
    rreg(8'h09, 8'h00);
    repeat (25) @(negedge clk);
    rreg(8'h09, 8'h40);
    inj.bus_active = 1'b1;
    wreg(8'h08, 8'h40);
    pulse(EV_SLP);
    @(negedge clk);
    check("sleep", 8'(cmds.sleep_mode), 8'h01);
    wreg(8'h08, 8'h00);
    pulse(EV_WRX);
    @(negedge clk);
    check("sleep", 8'(cmds.sleep_mode), 8'h00);
    wreg(8'h08, 8'h40);
    inj.bus_active = 1'b0;
    repeat (30) @(negedge clk);
    check("sleep", 8'(cmds.sleep_mode), 8'h01);
    $display("test sleep done");
    finish_test();
  end
endmodule // lin_control_status_regs_test

// ### dv/lin_engine_model.sv
// behavioural model of the lin bit engine facing the register block
`timescale 1ns/10ps
module lin_engine_model
  import lin_regs_pkg::*;
(
  input  wire logic        clk,     // system clock
  input  wire logic        resetn,  // synchronous reset, active low
  input  wire lin_cmds_t   cmds,    // commands from the register block
  input  wire lin_events_t inject,  // events ordered by the bench
  output lin_events_t      events   // events seen by the register block
);
  logic       busy_q;
  logic [3:0] wake_cnt_q;
  logic       sent_q;

  ////////////////////////////////////////////////////////////////////////////////
  // a started frame stays busy until it completes or fails
  always_ff @(posedge clk) begin
    if (!resetn || inject.frame_done || inject.bus_error) begin
      busy_q <= 1'b0;
    end else if (cmds.frame_start) begin
      busy_q <= 1'b1;
    end
  end

  // the wakeup signal takes eight cycles on the wire
  always_ff @(posedge clk) begin
    if (!resetn || !cmds.wakeup_send || sent_q) begin
      wake_cnt_q <= 4'h0;
    end else begin
      wake_cnt_q <= wake_cnt_q + 4'h1;
    end
    sent_q <= resetn && (wake_cnt_q == 4'h7);
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    events             = inject;
    events.frame_busy  = inject.frame_busy | busy_q;
    events.wakeup_sent = sent_q;
  end
endmodule // lin_engine_model

// ### hdl/lin_control_status_regs.sv
// control and status registers of the lin controller behind the indirect address/data pair
`timescale 1ns/10ps
`include "lin_regs_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - slave stop write blocks traffic until break
// - stop, interrupt-clear, error-clear read as zero
// - slave sleep bit enters sleep on frame/timeout
// - slave sleep clear: wakeup interrupt leaves sleep
// - direction bit: 1 transmit, 0 receive
// - data acknowledge clears itself
// - interrupt-clear strobe clears pending interrupt flag
// - error-clear strobe clears status and error detail
// - wakeup request sends wakeup, self-clears after
// - master start request begins frame transmission
// - start request clears on completion or error
// - activity bit follows bus activity
// - slave idle flag after four idle seconds
// - slave abort on early break or stop write
// - abort clears on non-interrupting break
// - all bits reset zero, status read-only
// - done clears at start, sets at finish
// - error sticky until error-clear strobe
// - role bit gates slave-only, master-only bits
module lin_control_status_regs
  import lin_regs_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = `IDLE_TIMEOUT_S * `CLK_HZ
) (
  input  wire logic        clk,          // system clock, 100 MHz
  input  wire logic        resetn,       // synchronous reset, active low
  input  wire logic        addr_wr,      // write strobe of the indirect address register
  input  wire logic        data_wr,      // write strobe of the indirect data register
  input  wire logic [7:0]  wdata,        // write data for either strobe
  input  wire logic        master_mode,  // role select, 1 master 0 slave
  input  wire lin_events_t events,       // events from the lin bit engine
  output logic      [7:0]  addr_q,       // indirect address register
  output logic      [7:0]  rdata_q,      // register selected by addr_q
  output lin_cmds_t        cmds_q        // commands to the lin bit engine
);

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic ctrl_wr;
  logic slave_mode;
  logic stop_wr;
  logic interrupt_clear_strobe_wr;
  logic error_clear_strobe_wr;
  logic data_acknowledge_wr;
  logic wakeup_request_wr;
  logic start_request_wr;
  logic idle_hit;

  // control storage
  logic sleep_q;
  logic dir_q;
  logic data_acknowledge_q;
  logic wakeup_request_q;
  logic start_request_q;
  logic halt_q;
  // status storage
  logic active_q;
  logic idle_q;
  logic abort_q;
  logic data_request_flag_q;
  logic int_q;
  logic error_q;
  logic wakeup_q;
  logic done_q;
  logic sleep_mode_q;
  logic [`IDLE_CNT_W-1:0] idle_cnt_q;

  assign slave_mode = !master_mode;
  assign ctrl_wr    = data_wr && (addr_q == `LIN_CTRL_ADDR);
  // slave-only and master-only bits are gated by the role
  assign stop_wr    = ctrl_wr && slave_mode && wdata[`CTRL_STOP_BIT];
  assign data_acknowledge_wr   = ctrl_wr && slave_mode && wdata[`CTRL_DATA_ACKNOWLEDGE_BIT];
  assign start_request_wr   = ctrl_wr && master_mode && wdata[`CTRL_START_REQUEST_BIT];
  assign interrupt_clear_strobe_wr  = ctrl_wr && wdata[`CTRL_INTERRUPT_CLEAR_STROBE_BIT];
  assign error_clear_strobe_wr  = ctrl_wr && wdata[`CTRL_ERROR_CLEAR_STROBE_BIT];
  assign wakeup_request_wr  = ctrl_wr && wdata[`CTRL_WAKEUP_REQUEST_BIT];
  assign idle_hit   = (idle_cnt_q == `IDLE_CNT_W'(IDLE_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // indirect address
  always_ff @(posedge clk) begin
    if (!resetn) begin
      addr_q <= `LIN_REG_RESET;
    end else if (addr_wr) begin
      addr_q <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; status register has no write path
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_q <= `LIN_REG_RESET;
    end else if (addr_q == `LIN_CTRL_ADDR) begin
      rdata_q <= {1'b0, sleep_q, dir_q, data_acknowledge_q, 1'b0, 1'b0, wakeup_request_q, start_request_q};
    end else if (addr_q == `LIN_STAT_ADDR) begin
      rdata_q <= {active_q, idle_q, abort_q, data_request_flag_q,
                  int_q, error_q, wakeup_q, done_q};
    end else begin
      rdata_q <= `LIN_REG_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // plain read/write control bits
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sleep_q <= 1'b0;
      dir_q   <= 1'b0;
    end else if (ctrl_wr) begin
      if (slave_mode) begin
        sleep_q <= wdata[`CTRL_SLEEP_BIT];
      end
      dir_q <= wdata[`CTRL_DIR_BIT];
    end
  end

  // self-clearing bits: a write setting the bit beats the hardware clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      data_acknowledge_q <= 1'b0;
    end else if (data_acknowledge_wr) begin
      data_acknowledge_q <= 1'b1;
    end else begin
      data_acknowledge_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wakeup_request_q <= 1'b0;
    end else if (wakeup_request_wr) begin
      wakeup_request_q <= 1'b1;
    end else if (events.wakeup_sent) begin
      wakeup_request_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      start_request_q <= 1'b0;
    end else if (start_request_wr) begin
      start_request_q <= 1'b1;
    end else if (events.frame_done || events.bus_error) begin
      start_request_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      halt_q <= 1'b0;
    end else if (stop_wr) begin
      halt_q <= 1'b1;
    end else if (events.break_det) begin
      halt_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // engine commands
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmds_q <= '0;
    end else begin
      cmds_q.frame_start <= start_request_wr;
      cmds_q.halt        <= halt_q || stop_wr;
      cmds_q.direction   <= dir_q;
      cmds_q.data_ack    <= data_acknowledge_wr;
      cmds_q.wakeup_send <= wakeup_request_q || wakeup_request_wr;
      cmds_q.error_clear <= error_clear_strobe_wr;
      cmds_q.sleep_mode  <= sleep_mode_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep state, slave only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sleep_mode_q <= 1'b0;
    end else if (master_mode) begin
      sleep_mode_q <= 1'b0;
    end else if (sleep_mode_q) begin
      if ((!sleep_q && events.wakeup_rx) || events.wakeup_sent) begin
        sleep_mode_q <= 1'b0;
      end
    end else if (sleep_q && (events.sleep_frame || idle_hit)) begin
      sleep_mode_q <= 1'b1;
    end
  end

  // idle counter runs while the bus is quiet, awake, in slave mode and not yet flagged idle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      idle_cnt_q <= '0;
    end else if (master_mode || events.bus_active || sleep_mode_q || idle_q) begin
      idle_cnt_q <= '0;
    end else begin
      idle_cnt_q <= idle_cnt_q + `IDLE_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      idle_q <= 1'b0;
    end else if (master_mode || events.bus_active || sleep_mode_q) begin
      idle_q <= 1'b0;
    end else if (idle_hit) begin
      idle_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags; hardware sets win over clears
  always_ff @(posedge clk) begin
    if (!resetn) begin
      active_q <= 1'b0;
    end else begin
      active_q <= events.bus_active;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      abort_q <= 1'b0;
    end else if (master_mode) begin
      abort_q <= 1'b0;
    end else if (stop_wr || (events.break_det && events.frame_busy)) begin
      abort_q <= 1'b1;
    end else if (events.break_det) begin
      abort_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      data_request_flag_q <= 1'b0;
    end else if (events.data_request && slave_mode) begin
      data_request_flag_q <= 1'b1;
    end else if (data_acknowledge_wr || stop_wr) begin
      data_request_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      int_q <= 1'b0;
    end else if (events.irq) begin
      int_q <= 1'b1;
    end else if (interrupt_clear_strobe_wr) begin
      int_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      error_q <= 1'b0;
    end else if (events.bus_error) begin
      error_q <= 1'b1;
    end else if (error_clear_strobe_wr) begin
      error_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wakeup_q <= 1'b0;
    end else if (events.wakeup_rx || wakeup_request_q) begin
      wakeup_q <= 1'b1;
    end else if (start_request_wr || events.break_det) begin
      wakeup_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      done_q <= 1'b0;
    end else if (events.frame_done) begin
      done_q <= 1'b1;
    end else if (start_request_wr || events.break_det) begin
      done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  halt_set_a: assert property (@(posedge clk) disable iff (!resetn)
    stop_wr |=> halt_q ##1 cmds_q.halt)
    else $error("halt not raised after stop write");

  strobe_reads_a: assert property (@(posedge clk) disable iff (!resetn)
    (addr_q == `LIN_CTRL_ADDR) && $stable(addr_q) |=> (rdata_q[7] == 1'b0)
      && (rdata_q[3] == 1'b0) && (rdata_q[2] == 1'b0))
    else $error("write-only strobe read back nonzero");

  sleep_enter_a: assert property (@(posedge clk) disable iff (!resetn)
    slave_mode && sleep_q && !sleep_mode_q && events.sleep_frame |=> sleep_mode_q)
    else $error("sleep not entered after sleep frame");

  dir_follow_a: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_wr |=> ##1 (cmds_q.direction == $past(wdata[`CTRL_DIR_BIT], 2)))
    else $error("direction command does not follow write");

  data_acknowledge_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    data_acknowledge_q && !data_acknowledge_wr |=> !data_acknowledge_q)
    else $error("data acknowledge not self-cleared");

  int_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    interrupt_clear_strobe_wr && !events.irq |=> !int_q)
    else $error("interrupt flag survived clear strobe");

  err_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    error_clear_strobe_wr && !events.bus_error |=> !error_q && cmds_q.error_clear)
    else $error("error clear strobe had no effect");

  start_request_end_a: assert property (@(posedge clk) disable iff (!resetn)
    start_request_q && !start_request_wr && (events.frame_done || events.bus_error) |=> !start_request_q)
    else $error("start request not returned to zero");

  active_follow_a: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> (active_q == $past(events.bus_active)))
    else $error("activity bit does not track bus");

  abort_set_a: assert property (@(posedge clk) disable iff (!resetn)
    slave_mode && events.break_det && events.frame_busy |=> abort_q)
    else $error("abort not set on early break");

  done_cycle_a: assert property (@(posedge clk) disable iff (!resetn)
    start_request_wr && !events.frame_done |=> !done_q)
    else $error("done not cleared at frame start");

  master_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    slave_mode && !start_request_q |=> !start_request_q)
    else $error("start request set in slave mode");

endmodule // lin_control_status_regs

// ### hdl/lin_regs_cfg.svh
// offsets, field positions and timing figures of the lin control and status registers
`ifndef LIN_REGS_CFG_SVH
`define LIN_REGS_CFG_SVH

`define LIN_CTRL_ADDR      8'h08
`define LIN_STAT_ADDR      8'h09
`define LIN_REG_RESET      8'h00

`define CTRL_STOP_BIT      7
`define CTRL_SLEEP_BIT     6
`define CTRL_DIR_BIT       5
`define CTRL_DATA_ACKNOWLEDGE_BIT     4
`define CTRL_INTERRUPT_CLEAR_STROBE_BIT    3
`define CTRL_ERROR_CLEAR_STROBE_BIT    2
`define CTRL_WAKEUP_REQUEST_BIT    1
`define CTRL_START_REQUEST_BIT     0

`define IDLE_TIMEOUT_S     4
`define CLK_HZ             100000000
`define IDLE_CNT_W         29

`endif

// ### hdl/lin_regs_pkg.sv
// types shared by the lin control and status register block
package lin_regs_pkg;

  // events and levels reported by the lin bit engine
  typedef struct packed {
    logic bus_active;    // activity seen on the bus
    logic break_det;     // one-cycle pulse, break field detected
    logic frame_busy;    // a transmission is pending or in progress
    logic frame_done;    // one-cycle pulse, transmission complete
    logic bus_error;     // one-cycle pulse, any bus error
    logic sleep_frame;   // one-cycle pulse, sleep-command frame received
    logic wakeup_rx;     // one-cycle pulse, wakeup signal received
    logic wakeup_sent;   // one-cycle pulse, wakeup signal transmitted
    logic data_request;  // one-cycle pulse, data identifier received
    logic irq;           // one-cycle pulse, interrupt event
  } lin_events_t;

  // commands and levels driven to the lin bit engine
  typedef struct packed {
    logic frame_start;   // one-cycle pulse, begin a frame
    logic halt;          // level, ignore traffic until next break
    logic direction;     // level, 1 transmit 0 receive
    logic data_ack;      // one-cycle pulse, data transfer acknowledged
    logic wakeup_send;   // level, send wakeup until wakeup_sent
    logic error_clear;   // one-cycle pulse, clear error detail register
    logic sleep_mode;    // level, device is in sleep
  } lin_cmds_t;

endpackage
